// ===== spi_core.sv
// SPI master and slave transfer core with APB register access.
// What this block does
// - Status read with tx empty, then data write, loads shifter and starts master transfer.
// - Master drives serial clock pin at rate from rate and prescale selects.
// - With fault detect and select output enabled, master drives SS low while busy.
// - Low SS input in master with fault detect set and select output clear clears master select, outputs off.
// - Mode fault during a transfer aborts it and forces idle.
// - Mode fault sets its flag; interrupt request raised when interrupt enable set.
// - Master waits a full serial clock cycle (lead half plus one run half) after data write before the first clock edge.
// - Changing format, rate or pin configuration bits in master aborts and idles.
// - With master select clear the clock pin is an input from the master.
// - SS must stay low through a slave transfer; early rise forces idle.
// - Slave output is released while SS high, first bit driven when low.
// - Slave ignores clock edges and does not shift while SS high.
// - Phase clear: slave latches input on odd edges, shifts on even edges.
// - Phase set: slave latches input on even edges, shifts on odd edges.
// - Both phases put first bit out at select; phase set does not shift on first edge.
// - After 8 or 16 shifts, word moves to receive buffer, rx full set.
// - Word length is 8 or 16 bits, chosen by the length select bit.
// - In 8-bit mode high data and match bytes read zero, writes ignored.
// - In 16-bit mode data bytes are read and written as coherent pairs.
// - In 16-bit mode match bytes are read and written as coherent pairs.
// - Toggling length select in master aborts, idles and resets all status.
// - Master clock is bus clock over prescale 1 to 8 and rate 2 to 256.
// - Bidirectional mode uses one data pin, direction from bidir output enable.
//
// The APB register port and the register addresses were chosen for this implementation.
`timescale 1ns/1ps

module spi_core (
  input wire logic clk,
  input wire logic rstn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire spi_core_pkg::pins_in_t pins_in,
  output spi_core_pkg::pins_out_t pins_out,
  output logic irq
);
  import spi_core_pkg::*;

  // ==========================================================================
  // Helper functions
  // ==========================================================================
  function automatic logic [15:0] shift_in(input logic [15:0] sh, input logic b,
                                           input logic lsb, input logic wide);
    logic [15:0] r;
    r = sh;
    if (wide)
    begin
      r = lsb ? {b, sh[15:1]} : {sh[14:0], b};
    end
    else
    begin
      r[7:0] = lsb ? {b, sh[7:1]} : {sh[6:0], b};
    end
    return r;
  endfunction

  function automatic logic out_bit(input logic [15:0] sh, input logic lsb, input logic wide);
    return lsb ? sh[0] : (wide ? sh[15] : sh[7]);
  endfunction

  // ==========================================================================
  // State and derived controls
  // ==========================================================================
  state_t state_reg;
  state_t state_next;
  logic master;
  logic wide;
  logic clock_phase_sel;
  logic lsb;
  logic fault_mode;
  logic ss_out_mode;
  logic bidir;
  logic [10:0] half_len;
  logic tick;
  logic slave_edge;
  logic fault_now;
  logic setup_ph;
  logic write_ph;
  logic done_pulse;

  assign master = state_reg.ctrl_one[C1_MASTER_SELECT] & state_reg.ctrl_one[C1_CORE_ENABLE];
  assign wide = state_reg.control_reg_two[C2_WORD_LENGTH];
  assign clock_phase_sel = state_reg.ctrl_one[C1_CLOCK_PHASE];
  assign lsb = state_reg.ctrl_one[C1_LSB_FIRST];
  assign bidir = state_reg.control_reg_two[C2_BIDIR_MODE];
  assign fault_mode = state_reg.control_reg_two[C2_FAULT_DETECT];
  assign ss_out_mode = fault_mode & state_reg.ctrl_one[C1_SELECT_OUTPUT];
  assign half_len = 11'({1'b0, state_reg.baud[6:4]} + 4'h1) << state_reg.baud[2:0];
  assign tick = (state_reg.xfer != XS_IDLE) && ({1'b0, state_reg.div_cnt} == half_len - 11'h1);
  assign slave_edge = !master && state_reg.ctrl_one[C1_CORE_ENABLE] && !state_reg.ss_sync[1]
                      && (state_reg.sclk_sync[1] != state_reg.sclk_sync[2]);
  assign fault_now = master && fault_mode && !ss_out_mode && !state_reg.ss_sync[1];
  assign setup_ph = psel && !penable;
  assign write_ph = psel && penable && pwrite;

  // ==========================================================================
  // Next-state logic
  // ==========================================================================
  always_comb
  begin
    logic [5:0] ec;
    logic [5:0] last;
    logic din;
    logic samp;
    logic abort;
    logic hi;
    int k;
    logic [15:0] val;
    logic [7:0] w;
    state_next = state_reg;
    ec = state_reg.edge_cnt + 6'h1;
    last = wide ? EDGES_WORD : EDGES_BYTE;
    din = 1'b0;
    samp = 1'b0;
    abort = 1'b0;
    hi = 1'b0;
    k = 0;
    val = 16'h0000;
    w = 8'h00;
    done_pulse = 1'b0;
    state_next.sclk_sync = {state_reg.sclk_sync[1:0], pins_in.sclk};
    state_next.ss_sync = {state_reg.ss_sync[0], pins_in.ss_n};
    state_next.mosi_sync = {state_reg.mosi_sync[0], pins_in.mosi};
    state_next.miso_sync = {state_reg.miso_sync[0], pins_in.miso};

    // Register reads act in the setup cycle so that read data comes from a flip-flop.
    if (setup_ph)
    begin
      state_next.prdata = 32'h0000_0000;
      state_next.pslverr = 1'b0;
      if (paddr == OFF_CTRL_ONE)
      begin
        state_next.prdata[7:0] = state_reg.ctrl_one;
      end
      else if (paddr == OFF_CONTROL_REG_TWO)
      begin
        state_next.prdata[7:0] = state_reg.control_reg_two;
      end
      else if (paddr == OFF_BAUD)
      begin
        state_next.prdata[7:0] = state_reg.baud;
      end
      else if (paddr == OFF_SERIAL_STATUS)
      begin
        state_next.prdata[ST_RX_FULL] = state_reg.rx_full_flag;
        state_next.prdata[ST_MATCH] = state_reg.match_flag;
        state_next.prdata[ST_TX_EMPTY] = state_reg.tx_empty_flag;
        state_next.prdata[ST_MODE_FAULT] = state_reg.mode_fault_flag;
        if (!pwrite)
        begin
          state_next.tx_armed = state_reg.tx_empty_flag;
          state_next.fault_armed = state_reg.mode_fault_flag;
          state_next.rx_armed = state_reg.rx_full_flag;
          state_next.match_armed = state_reg.match_flag;
        end
      end
      else if (paddr == OFF_DATA_HIGH || paddr == OFF_DATA_LOW
               || paddr == OFF_MATCH_HIGH || paddr == OFF_MATCH_LOW)
      begin
        k = (paddr == OFF_MATCH_HIGH || paddr == OFF_MATCH_LOW) ? 1 : 0;
        hi = (paddr == OFF_DATA_HIGH || paddr == OFF_MATCH_HIGH);
        val = (k == 1) ? state_reg.match_val : state_reg.rx_buf;
        if (!pwrite)
        begin
          if (!wide)
          begin
            state_next.prdata[7:0] = hi ? 8'h00 : val[7:0];
          end
          else if (state_reg.rd_held[k] && state_reg.rd_high[k] != hi)
          begin
            w = hi ? state_reg.rd_hold[k][15:8] : state_reg.rd_hold[k][7:0];
            state_next.prdata[7:0] = w;
            state_next.rd_held[k] = 1'b0;
          end
          else
          begin
            state_next.rd_hold[k] = val;
            state_next.rd_held[k] = 1'b1;
            state_next.rd_high[k] = hi;
            state_next.prdata[7:0] = hi ? val[15:8] : val[7:0];
          end
          if (k == 0 && state_reg.rx_armed)
          begin
            state_next.rx_full_flag = 1'b0;
            state_next.rx_armed = 1'b0;
          end
        end
      end
      else
      begin
        state_next.pslverr = 1'b1;
      end
    end

    // Register writes act at the access edge.
    if (write_ph)
    begin
      if (paddr == OFF_CTRL_ONE)
      begin
        abort = master && |((pwdata[7:0] ^ state_reg.ctrl_one) & C1_ABORT_MASK);
        if (state_reg.fault_armed)
        begin
          state_next.mode_fault_flag = 1'b0;
          state_next.fault_armed = 1'b0;
        end
        state_next.ctrl_one = pwdata[7:0] & C1_WRITE_MASK;
      end
      else if (paddr == OFF_CONTROL_REG_TWO)
      begin
        w = (pwdata[7:0] ^ state_reg.control_reg_two) & C2_ABORT_MASK;
        if (bidir || pwdata[C2_BIDIR_MODE])
        begin
          w[C2_BIDIR_OUTPUT] = pwdata[C2_BIDIR_OUTPUT] ^ state_reg.control_reg_two[C2_BIDIR_OUTPUT];
        end
        abort = master && (w != 8'h00);
        if (master && w[C2_WORD_LENGTH])
        begin
          state_next.rx_full_flag = 1'b0;
          state_next.match_flag = 1'b0;
          state_next.mode_fault_flag = 1'b0;
          state_next.tx_empty_flag = 1'b1;
          state_next.tx_armed = 1'b0;
          state_next.fault_armed = 1'b0;
          state_next.rx_armed = 1'b0;
          state_next.match_armed = 1'b0;
          state_next.wr_got = '0;
          state_next.rd_held = '0;
        end
        state_next.control_reg_two = pwdata[7:0] & C2_WRITE_MASK;
      end
      else if (paddr == OFF_BAUD)
      begin
        abort = master && |((pwdata[7:0] ^ state_reg.baud) & BAUD_WRITE_MASK);
        state_next.baud = pwdata[7:0] & BAUD_WRITE_MASK;
      end
      else if (paddr == OFF_SERIAL_STATUS)
      begin
        if (pwdata[ST_MATCH] && state_reg.match_armed)
        begin
          state_next.match_flag = 1'b0;
          state_next.match_armed = 1'b0;
        end
      end
      else if (paddr == OFF_DATA_HIGH || paddr == OFF_DATA_LOW
               || paddr == OFF_MATCH_HIGH || paddr == OFF_MATCH_LOW)
      begin
        k = (paddr == OFF_MATCH_HIGH || paddr == OFF_MATCH_LOW) ? 1 : 0;
        hi = (paddr == OFF_DATA_HIGH || paddr == OFF_MATCH_HIGH);
        if (!wide)
        begin
          if (!hi)
          begin
            state_next.wr_hold[k] = {8'h00, pwdata[7:0]};
            state_next.wr_got[k] = 2'b11;
          end
        end
        else if (hi)
        begin
          state_next.wr_hold[k][15:8] = pwdata[7:0];
          state_next.wr_got[k][1] = 1'b1;
        end
        else
        begin
          state_next.wr_hold[k][7:0] = pwdata[7:0];
          state_next.wr_got[k][0] = 1'b1;
        end
        if (state_next.wr_got[k] == 2'b11)
        begin
          state_next.wr_got[k] = 2'b00;
          if (k == 1)
          begin
            state_next.match_val = state_next.wr_hold[1];
          end
          else if (state_reg.tx_armed)
          begin
            state_next.tx_buf = state_next.wr_hold[0];
            state_next.tx_empty_flag = 1'b0;
            state_next.tx_armed = 1'b0;
          end
        end
      end
    end

    // Serial engine: master sequencing and slave edge handling.
    din = master ? (bidir ? state_reg.mosi_sync[1] : state_reg.miso_sync[1])
                 : (bidir ? state_reg.miso_sync[1] : state_reg.mosi_sync[1]);
    if (abort || !state_reg.ctrl_one[C1_CORE_ENABLE])
    begin
      state_next.xfer = XS_IDLE;
      state_next.edge_cnt = 6'h00;
      state_next.div_cnt = 10'h000;
      state_next.sclk_phase = 1'b0;
    end
    else if (!master && state_reg.ss_sync[1])
    begin
      state_next.edge_cnt = 6'h00;
      state_next.xfer = XS_IDLE;
    end
    else
    begin
      if (state_reg.xfer != XS_IDLE)
      begin
        state_next.div_cnt = tick ? 10'h000 : state_reg.div_cnt + 10'h001;
      end
      if ((master && state_reg.xfer == XS_RUN && tick) || slave_edge)
      begin
        state_next.sclk_phase = !state_reg.sclk_phase;
        state_next.edge_cnt = ec;
        samp = clock_phase_sel ? !ec[0] : ec[0];
        if (samp)
        begin
          state_next.sample = din;
          if (clock_phase_sel && ec == last)
          begin
            state_next.shifter = shift_in(state_reg.shifter, din, lsb, wide);
          end
        end
        else if (!(clock_phase_sel && ec == 6'h01))
        begin
          state_next.shifter = shift_in(state_reg.shifter, state_reg.sample, lsb, wide);
        end
        if (ec == last)
        begin
          done_pulse = 1'b1;
          state_next.rx_buf = wide ? state_next.shifter : {8'h00, state_next.shifter[7:0]};
          state_next.rx_full_flag = 1'b1;
          state_next.match_flag = (state_next.rx_buf == state_reg.match_val)
                                  || state_next.match_flag;
          state_next.edge_cnt = 6'h00;
          if (master)
          begin
            state_next.xfer = XS_TAIL;
          end
        end
      end
      else if (master && state_reg.xfer == XS_LEAD && tick)
      begin
        state_next.xfer = XS_RUN;
      end
      else if (master && state_reg.xfer == XS_TAIL && tick)
      begin
        state_next.xfer = XS_IDLE;
      end
      else if (state_reg.xfer == XS_IDLE && !state_reg.tx_empty_flag
               && state_reg.edge_cnt == 6'h00 && !slave_edge)
      begin
        state_next.shifter = state_reg.tx_buf;
        state_next.tx_empty_flag = 1'b1;
        state_next.div_cnt = 10'h000;
        if (master)
        begin
          state_next.xfer = XS_LEAD;
        end
      end
    end

    // A mode fault overrides the serial engine and master select in the same cycle.
    if (fault_now)
    begin
      state_next.ctrl_one[C1_MASTER_SELECT] = 1'b0;
      state_next.mode_fault_flag = 1'b1;
      state_next.xfer = XS_IDLE;
      state_next.edge_cnt = 6'h00;
      state_next.div_cnt = 10'h000;
      state_next.sclk_phase = 1'b0;
    end
  end

  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      state_reg <= '0;
      state_reg.ctrl_one <= CTRL_ONE_RESET;
      state_reg.control_reg_two <= CTRL_TWO_RESET;
      state_reg.baud <= BAUD_RESET;
      state_reg.tx_empty_flag <= 1'b1;
      state_reg.xfer <= XS_IDLE;
      state_reg.sclk_sync <= 3'h0;
      state_reg.ss_sync <= 2'h3;
    end
    else
    begin
      state_reg <= state_next;
    end
  end

  // ==========================================================================
  // Outputs and pin drive
  // ==========================================================================
  assign prdata = state_reg.prdata;
  assign pslverr = state_reg.pslverr;
  assign pready = 1'b1;
  assign irq = state_reg.ctrl_one[C1_IRQ_ENABLE]
               & (state_reg.mode_fault_flag | state_reg.rx_full_flag);

  always_comb
  begin
    logic sbit;
    sbit = out_bit(state_reg.shifter, lsb, wide);
    pins_out = '0;
    pins_out.ss_n_o = 1'b1;
    pins_out.mosi_o = sbit;
    pins_out.miso_o = sbit;
    if (master)
    begin
      pins_out.sclk_oe = 1'b1;
      pins_out.sclk_o = state_reg.ctrl_one[C1_CLOCK_POLARITY] ^ state_reg.sclk_phase;
      pins_out.ss_n_oe = ss_out_mode;
      pins_out.ss_n_o = (state_reg.xfer == XS_IDLE);
      pins_out.mosi_oe = bidir ? state_reg.control_reg_two[C2_BIDIR_OUTPUT] : 1'b1;
    end
    else if (state_reg.ctrl_one[C1_CORE_ENABLE] && !state_reg.ss_sync[1]
             && !state_reg.mode_fault_flag)
    begin
      pins_out.miso_oe = bidir ? state_reg.control_reg_two[C2_BIDIR_OUTPUT] : 1'b1;
    end
  end

  // ==========================================================================
  // Assertions
  // ==========================================================================
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rstn);

  a_fault_drops_master: assert property (fault_now |=> !master && state_reg.mode_fault_flag)
    else $error("mode fault did not drop master select");
  a_fault_aborts_xfer: assert property (fault_now |=> state_reg.xfer == XS_IDLE
    && !pins_out.sclk_oe && !pins_out.mosi_oe && !pins_out.miso_oe)
    else $error("mode fault did not abort");
  a_fault_irq_raised: assert property ($rose(state_reg.mode_fault_flag)
    && state_reg.ctrl_one[C1_IRQ_ENABLE] |-> irq) else $error("mode fault irq missing");
  a_ss_low_busy: assert property (master && ss_out_mode |->
    pins_out.ss_n_oe && (pins_out.ss_n_o == (state_reg.xfer == XS_IDLE)))
    else $error("select output wrong");
  a_master_drives_clk: assert property (master |-> pins_out.sclk_oe)
    else $error("master clock not driven");
  a_slave_clk_input: assert property (!master |-> !pins_out.sclk_oe)
    else $error("slave drives clock");
  a_slave_out_hiz: assert property (!master && state_reg.ss_sync[1] |-> !pins_out.miso_oe)
    else $error("slave output driven while deselected");
  a_slave_ignores_clk: assert property (!master && state_reg.ss_sync[1]
    |=> state_reg.edge_cnt == 6'h00 && $stable(state_reg.shifter))
    else $error("slave shifted while deselected");
  a_lead_half_wait: assert property ($rose(state_reg.xfer == XS_LEAD)
    |-> state_reg.div_cnt == 10'h000 && state_reg.edge_cnt == 6'h00)
    else $error("lead phase started mid count");
  a_done_sets_rxf: assert property (done_pulse |=> state_reg.rx_full_flag)
    else $error("rx full not set at completion");
  a_idle_no_edges: assert property (master && state_reg.xfer == XS_IDLE
    && state_reg.tx_empty_flag && !write_ph |=> state_reg.xfer == XS_IDLE)
    else $error("master left idle without data");
  a_length_resets: assert property (write_ph && master && paddr == OFF_CONTROL_REG_TWO
    && (pwdata[C2_WORD_LENGTH] != wide) && !fault_now |=> state_reg.xfer == XS_IDLE
    && state_reg.tx_empty_flag && !state_reg.match_flag) else $error("length change no reset");

endmodule // spi_core

// ===== spi_core_pkg.sv
// Package with register map, field positions, reset values and state types of the SPI core.
package spi_core_pkg;

  // ==========================================================================
  // Register byte offsets on APB
  // ==========================================================================
  localparam logic [7:0] OFF_CTRL_ONE = 8'h00;
  localparam logic [7:0] OFF_CONTROL_REG_TWO = 8'h04;
  localparam logic [7:0] OFF_BAUD = 8'h08;
  localparam logic [7:0] OFF_SERIAL_STATUS = 8'h0C;
  localparam logic [7:0] OFF_DATA_HIGH = 8'h10;
  localparam logic [7:0] OFF_DATA_LOW = 8'h14;
  localparam logic [7:0] OFF_MATCH_HIGH = 8'h18;
  localparam logic [7:0] OFF_MATCH_LOW = 8'h1C;

  // ==========================================================================
  // Field positions
  // ==========================================================================
  localparam int C1_IRQ_ENABLE = 7;
  localparam int C1_CORE_ENABLE = 6;
  localparam int C1_MASTER_SELECT = 4;
  localparam int C1_CLOCK_POLARITY = 3;
  localparam int C1_CLOCK_PHASE = 2;
  localparam int C1_SELECT_OUTPUT = 1;
  localparam int C1_LSB_FIRST = 0;
  localparam int C2_WORD_LENGTH = 6;
  localparam int C2_FAULT_DETECT = 4;
  localparam int C2_BIDIR_OUTPUT = 3;
  localparam int C2_BIDIR_MODE = 0;
  localparam int ST_RX_FULL = 7;
  localparam int ST_MATCH = 6;
  localparam int ST_TX_EMPTY = 5;
  localparam int ST_MODE_FAULT = 4;

  // ==========================================================================
  // Write masks, abort masks and reset values
  // ==========================================================================
  localparam logic [7:0] C1_WRITE_MASK = 8'hDF;
  localparam logic [7:0] C1_ABORT_MASK = 8'h0F;
  localparam logic [7:0] C2_WRITE_MASK = 8'h59;
  localparam logic [7:0] C2_ABORT_MASK = 8'h51;
  localparam logic [7:0] BAUD_WRITE_MASK = 8'h77;
  localparam logic [7:0] CTRL_ONE_RESET = 8'h04;
  localparam logic [7:0] CTRL_TWO_RESET = 8'h00;
  localparam logic [7:0] BAUD_RESET = 8'h00;
  localparam logic [5:0] EDGES_BYTE = 6'h10;
  localparam logic [5:0] EDGES_WORD = 6'h20;

  // ==========================================================================
  // Types
  // ==========================================================================
  typedef enum logic [1:0] {
    XS_IDLE = 2'b00,
    XS_LEAD = 2'b01,
    XS_RUN = 2'b11,
    XS_TAIL = 2'b10
  } xfer_state_t;

  typedef struct packed {
    logic sclk;
    logic mosi;
    logic miso;
    logic ss_n;
  } pins_in_t;

  typedef struct packed {
    logic sclk_o;
    logic sclk_oe;
    logic mosi_o;
    logic mosi_oe;
    logic miso_o;
    logic miso_oe;
    logic ss_n_o;
    logic ss_n_oe;
  } pins_out_t;

  typedef struct packed {
    logic [7:0] ctrl_one;
    logic [7:0] control_reg_two;
    logic [7:0] baud;
    logic rx_full_flag;
    logic match_flag;
    logic tx_empty_flag;
    logic mode_fault_flag;
    logic tx_armed;
    logic fault_armed;
    logic rx_armed;
    logic match_armed;
    logic [15:0] tx_buf;
    logic [15:0] rx_buf;
    logic [15:0] match_val;
    logic [15:0] shifter;
    logic sample;
    logic [1:0][15:0] rd_hold;
    logic [1:0] rd_held;
    logic [1:0] rd_high;
    logic [1:0][15:0] wr_hold;
    logic [1:0][1:0] wr_got;
    xfer_state_t xfer;
    logic [9:0] div_cnt;
    logic [5:0] edge_cnt;
    logic sclk_phase;
    logic [2:0] sclk_sync;
    logic [1:0] ss_sync;
    logic [1:0] mosi_sync;
    logic [1:0] miso_sync;
    logic [31:0] prdata;
    logic pslverr;
  } state_t;

endpackage

// ===== spi_core_tb_top.sv
// Self-checking testbench of the SPI core with APB register access.
`timescale 1ns/1ps
module spi_core_tb_top;
  import spi_core_pkg::*;
  logic clk = 1'b0, rstn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, ss_tb = 1'b1;
  logic sclk_tb = 1'b0, mosi_tb = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, r;
  logic pready, pslverr, irq, miso_w;
  logic [7:0] got;
  pins_in_t pins_in;
  pins_out_t po;
  int n_errors = 0, checked = 0, low_cnt = 0;
  always #5 clk = ~clk;
  assign pins_in = {po.sclk_oe ? po.sclk_o : sclk_tb, po.mosi_oe ? po.mosi_o : mosi_tb, miso_w,
                    po.ss_n_oe ? po.ss_n_o : ss_tb};
  always @(posedge clk) if (po.ss_n_oe && !po.ss_n_o) low_cnt++;
  spi_core i_spi_core (.clk(clk), .rstn(rstn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .pins_in(pins_in), .pins_out(po), .irq(irq));
  spi_far_side i_spi_far_side (.sclk(pins_in.sclk), .mosi(pins_in.mosi),
    .ss_n(pins_in.ss_n), .miso(miso_w), .got(got));
  // ==========================================================================
  // Shared tasks
  // ==========================================================================
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do
    begin
      @(posedge clk);
    end
    while (pready !== 1'b1);
    r = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic poll(input int b);
    int n;
    n = 0;
    do
    begin
      apb(1'b0, OFF_SERIAL_STATUS, 32'h0);
      n++;
    end
    while (r[b] !== 1'b1 && n < 300);
  endtask
  task automatic print_verdict();
    $display("checked=%0d n_errors=%0d", checked, n_errors);
    if (n_errors == 0 && checked > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  // ==========================================================================
  // Scenarios
  // ==========================================================================
  task automatic t_reset();
    apb(1'b0, OFF_CTRL_ONE, 32'h0);
    check(r, 32'h04);
    apb(1'b0, OFF_SERIAL_STATUS, 32'h0);
    check(r, 32'h20);
    apb(1'b0, 8'h20, 32'h0);
    check({31'h0, pslverr}, 32'h1);
  endtask
  task automatic t_match();
    apb(1'b1, OFF_CONTROL_REG_TWO, 32'h40);
    apb(1'b1, OFF_MATCH_HIGH, 32'h12);
    apb(1'b1, OFF_MATCH_LOW, 32'h34);
    apb(1'b0, OFF_MATCH_HIGH, 32'h0);
    check(r, 32'h12);
    apb(1'b0, OFF_MATCH_LOW, 32'h0);
    check(r, 32'h34);
    apb(1'b1, OFF_CONTROL_REG_TWO, 32'h00);
    apb(1'b1, OFF_DATA_HIGH, 32'h77);
    apb(1'b0, OFF_DATA_HIGH, 32'h0);
    check(r, 32'h0);
    apb(1'b0, OFF_MATCH_HIGH, 32'h0);
    check(r, 32'h0);
  endtask
  task automatic t_master();
    apb(1'b1, OFF_CONTROL_REG_TWO, 32'h10);
    apb(1'b1, OFF_BAUD, 32'h03);
    apb(1'b1, OFF_CTRL_ONE, 32'h52);
    apb(1'b0, OFF_SERIAL_STATUS, 32'h0);
    apb(1'b1, OFF_DATA_LOW, 32'hA5);
    poll(ST_RX_FULL);
    check(r & 32'h80, 32'h80);
    apb(1'b0, OFF_DATA_LOW, 32'h0);
    check(r, 32'h3C);
    check({24'h0, got}, 32'hA5);
    check({31'h0, low_cnt != 0}, 32'h1);
    repeat (20) @(posedge clk);
    check({31'h0, pins_in.ss_n}, 32'h1);
  endtask
  task automatic t_abort();
    apb(1'b0, OFF_SERIAL_STATUS, 32'h0);
    apb(1'b1, OFF_DATA_LOW, 32'h0F);
    repeat (40) @(posedge clk);
    check({31'h0, pins_in.ss_n}, 32'h0);
    apb(1'b1, OFF_CONTROL_REG_TWO, 32'h50);
    repeat (200) @(posedge clk);
    apb(1'b0, OFF_SERIAL_STATUS, 32'h0);
    check(r, 32'h20);
    check({31'h0, pins_in.ss_n}, 32'h1);
  endtask
  task automatic t_fault();
    apb(1'b1, OFF_CTRL_ONE, 32'hD0);
    ss_tb <= 1'b0;
    poll(ST_MODE_FAULT);
    check(r & 32'h10, 32'h10);
    check({31'h0, irq}, 32'h1);
    apb(1'b0, OFF_CTRL_ONE, 32'h0);
    check(r & 32'h10, 32'h0);
    check({31'h0, po.sclk_oe | po.mosi_oe | po.miso_oe}, 32'h0);
    ss_tb <= 1'b1;
  endtask
  task automatic t_slave();
    logic [15:0] sb;
    logic [15:0] tx;
    sb = 16'h0000;
    tx = 16'hA55A;
    apb(1'b1, OFF_CTRL_ONE, 32'h40);
    apb(1'b0, OFF_SERIAL_STATUS, 32'h0);
    apb(1'b1, OFF_DATA_HIGH, 32'hC3);
    apb(1'b1, OFF_DATA_LOW, 32'h96);
    ss_tb <= 1'b0;
    repeat (8) @(posedge clk);
    check({31'h0, po.miso_oe}, 32'h1);
    for (int i = 15; i >= 0; i--)
    begin
      mosi_tb <= tx[i];
      repeat (8) @(posedge clk);
      sb = {sb[14:0], po.miso_o};
      sclk_tb <= 1'b1;
      repeat (8) @(posedge clk);
      sclk_tb <= 1'b0;
    end
    repeat (8) @(posedge clk);
    ss_tb <= 1'b1;
    repeat (4) @(posedge clk);
    check({31'h0, po.miso_oe}, 32'h0);
    check({16'h0, sb}, 32'hC396);
    apb(1'b0, OFF_SERIAL_STATUS, 32'h0);
    check(r & 32'h80, 32'h80);
    apb(1'b0, OFF_DATA_HIGH, 32'h0);
    check(r, 32'hA5);
    apb(1'b0, OFF_DATA_LOW, 32'h0);
    check(r, 32'h5A);
  endtask
  initial
  begin
    repeat (2) @(posedge clk);
    rstn <= 1'b1;
    t_reset();
    t_match();
    t_master();
    t_abort();
    t_fault();
    t_slave();
    print_verdict();
  end
  initial
  begin
    #100000;
    n_errors++;
    print_verdict();
  end
endmodule // spi_core_tb_top

// ===== spi_far_side.sv
// Behavioural far-side SPI slave: clock phase clear, MSB first, 8-bit words.
`timescale 1ns/1ps
module spi_far_side #(
  parameter logic [7:0] REPLY = 8'h3C
) (
  input wire logic sclk,
  input wire logic mosi,
  input wire logic ss_n,
  output logic miso,
  output logic [7:0] got
);
  logic [7:0] sh = 8'h00;
  initial miso = 1'b0;
  initial got = 8'h00;
  // First bit goes out as soon as the slave is selected.
  always @(negedge ss_n)
  begin
    sh = REPLY;
    miso = REPLY[7];
  end
  always @(posedge sclk) if (!ss_n) got = {got[6:0], mosi};
  always @(negedge sclk)
  begin
    if (!ss_n) sh = {sh[6:0], 1'b0};
    if (!ss_n) miso = sh[7];
  end
  // A released line shows the inverse of its last level.
  always @(posedge ss_n) miso = ~miso;
endmodule // spi_far_side
